// ### rtl/ssc_pkg.sv
// Package of constants, types and register layout for the strain sequence configuration block.
`default_nettype none
package ssc_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_MAP = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;
  // Field layout of the configuration register.
  localparam int CFG_W = 9;
  localparam logic [CFG_W-1:0] CFG_RESET = 9'h000;
  localparam logic [7:0] MAP_RESET = 8'hE4;
  localparam int CTRL_INIT_BIT = 0;
  // Status bits.
  localparam int ST_RESULT = 0;
  localparam int ST_FAKE_DONE = 1;
  localparam int ST_CONFLICT = 19;
  localparam logic [31:0] STAT_IMPL = 32'h0008_0003;
  // Calibration interval coding.
  localparam logic [3:0] CAL_TOP_CODE = 4'hF;
  localparam logic [3:0] CAL_TOP_PERIOD = 4'hF;
  // Result arithmetic.
  localparam int RES_W = 16;
  localparam int NUM_W = 40;
  localparam int DEN_W = RES_W + 1;
  localparam logic [19:0] PPM_SCALE = 20'hF4240;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic single_conv;
    logic osc_off_en;
    logic quarter_bridge;
    logic [3:0] calib_interval;
    logic [1:0] dummy_count;
  } ssc_cfg_t;

  typedef enum logic [1:0] {
    SSC_IDLE = 2'h0,
    SSC_FAKE = 2'h1,
    SSC_RUN = 2'h3
  } ssc_state_t;

  // Number of inserted fake measurements for a dummy-count code.
  function automatic logic [2:0] ssc_fake_count(input logic [1:0] code);
    case (code)
      2'h0: ssc_fake_count = 3'h0;
      2'h1: ssc_fake_count = 3'h1;
      2'h2: ssc_fake_count = 3'h2;
      default: ssc_fake_count = 3'h4;
    endcase
  endfunction
endpackage
`default_nettype wire

// ### rtl/ssc_divider.sv
// Sequential restoring divider producing the signed ppm quotient.
`default_nettype none
module ssc_divider (
  // Clocking.
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Request.
  input wire logic start,
  input wire logic [ssc_pkg::NUM_W-1:0] num_mag,
  input wire logic [ssc_pkg::DEN_W-1:0] den,
  input wire logic neg,
  // Answer.
  output logic busy,
  output logic done,
  output logic [31:0] quot
);
  logic [ssc_pkg::NUM_W-1:0] q;
  logic [ssc_pkg::DEN_W-1:0] rem;
  logic [5:0] cnt;
  logic neg_r;
  logic [ssc_pkg::DEN_W-1:0] den_r;
  logic [ssc_pkg::DEN_W:0] shifted;
  logic [ssc_pkg::DEN_W:0] diff;
  logic ge;
  logic [ssc_pkg::NUM_W-1:0] next_q;

  always_comb begin
    shifted = {rem, q[ssc_pkg::NUM_W-1]};
    diff = shifted - {1'b0, den_r};
    ge = shifted >= {1'b0, den_r};
    next_q = {q[ssc_pkg::NUM_W-2:0], ge};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      busy <= 1'b0;
      done <= 1'b0;
      quot <= 32'h0000_0000;
      q <= '0;
      rem <= '0;
      cnt <= 6'h00;
      neg_r <= 1'b0;
      den_r <= '0;
    end else if (ce) begin
      done <= 1'b0;
      if (start && !busy) begin
        q <= num_mag;
        rem <= '0;
        cnt <= 6'(ssc_pkg::NUM_W);
        neg_r <= neg;
        den_r <= den;
        busy <= 1'b1;
      end else if (busy) begin
        q <= next_q;
        rem <= ge ? diff[ssc_pkg::DEN_W-1:0] : shifted[ssc_pkg::DEN_W-1:0];
        cnt <= cnt - 6'h01;
        if (cnt == 6'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
          quot <= neg_r ? -next_q[31:0] : next_q[31:0];
        end
      end
    end
  end
endmodule // ssc_divider
`default_nettype wire

// ### rtl/ssc_top.sv
// Configuration, fake-cycle sequencing, port mapping and result formula of the strain front end.
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none
//////////////////////////////////////////////////////////////////////////////////////////////
// Function
// - Both arithmetic units hitting shared RAM together sets sticky status bit 19.
// - Dummy code 0,1,2,3 inserts 0,1,2,4 fake measurements; four at most.
// - Fake measurements run after reset, produce no result and no output.
// - Calibration interval code n calibrates every n+1 cycles; code 15 every 15.
// - Each 2-bit select routes its drive position to pair A, B, C or D.
// - After reset every drive position maps to its own port pair.
// - Any select combination, duplicates too, is accepted without lock-up.
// - Half-bridge result is one million times difference over sum.
// - Quarter-bridge result is one million times difference over twice reference.
// - Single-conversion mode may switch the fast oscillator off between conversions.
module ssc_top (
  // Clocking.
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // AXI4-Lite write address and data.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt.
  output logic irq,
  // Measurement core status.
  input wire logic seq_start,
  input wire logic cycle_done,
  input wire logic first_arith_unit_ram,
  input wire logic second_arith_unit_ram,
  input wire logic conv_busy,
  // Gauge data.
  input wire logic gauge_valid,
  input wire logic [ssc_pkg::RES_W-1:0] gauge_r1,
  input wire logic [ssc_pkg::RES_W-1:0] gauge_r2,
  // Drivers and control outputs.
  input wire logic [3:0] drive_pos,
  output logic [3:0] port_pair_drive,
  output logic fake_active,
  output logic calib_req,
  output logic osc_off,
  // Result.
  output logic [31:0] result_ppm,
  output logic result_valid
);
  //////////////////////////////////////////////////////////////////////////////////////////////
  // Register state.
  ssc_pkg::ssc_cfg_t cfg;
  ssc_pkg::ssc_cfg_t act_cfg;
  logic [7:0] pair_map;
  logic [7:0] act_map;
  logic [31:0] status;
  logic [31:0] mask;
  logic init_pend;
  logic soft_init;

  // Write channel holding registers.
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_err;

  // Sequencer.
  ssc_pkg::ssc_state_t state;
  ssc_pkg::ssc_state_t next_state;
  logic [2:0] fake_cnt;
  logic [2:0] fake_goal;
  logic [3:0] cal_cnt;
  logic [3:0] cal_period;
  logic [3:0] pair_hit;

  // Arithmetic.
  logic [ssc_pkg::RES_W:0] sdiff;
  logic [ssc_pkg::RES_W-1:0] mag;
  logic [ssc_pkg::DEN_W-1:0] den;
  logic [ssc_pkg::NUM_W-1:0] num_mag;
  logic div_start;
  logic div_busy;
  logic div_done;
  logic [31:0] div_quot;
  logic div_keep;

  // Events.
  logic ev_conflict;
  logic ev_fake_done;

  // Merges write data into an old value under byte strobes.
  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // True when a drive position selects a given pair.
  function automatic logic sel_hit(input logic [7:0] map, input int pos, input int pair);
    return map[pos*2 +: 2] == 2'(pair);
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave. Only one write and one read are accepted at a time.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_comb begin
    wr_err = 1'b1;
    if (aw_addr == ssc_pkg::OFS_CFG) begin
      wr_err = 1'b0;
    end else if (aw_addr == ssc_pkg::OFS_MAP) begin
      wr_err = 1'b0;
    end else if (aw_addr == ssc_pkg::OFS_CTRL) begin
      wr_err = 1'b0;
    end else if (aw_addr == ssc_pkg::OFS_STAT) begin
      wr_err = 1'b0;
    end else if (aw_addr == ssc_pkg::OFS_MASK) begin
      wr_err = 1'b0;
    end else if (aw_addr == ssc_pkg::OFS_RESULT) begin
      wr_err = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ssc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_err ? ssc_pkg::RESP_SLVERR : ssc_pkg::RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ssc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= ssc_pkg::RESP_OKAY;
        if (s_axi_araddr == ssc_pkg::OFS_CFG) begin
          s_axi_rdata <= 32'(cfg);
        end else if (s_axi_araddr == ssc_pkg::OFS_MAP) begin
          s_axi_rdata <= {24'h000000, pair_map};
        end else if (s_axi_araddr == ssc_pkg::OFS_CTRL) begin
          s_axi_rdata <= {28'h0000000, state, div_busy, init_pend};
        end else if (s_axi_araddr == ssc_pkg::OFS_STAT) begin
          s_axi_rdata <= status;
        end else if (s_axi_araddr == ssc_pkg::OFS_MASK) begin
          s_axi_rdata <= mask;
        end else if (s_axi_araddr == ssc_pkg::OFS_RESULT) begin
          s_axi_rdata <= result_ppm;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= ssc_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Software-visible configuration. Writes land here but the sequencer only copies them
  // at the first sequence after an init, so a running sequence never sees a half-changed setup.
  assign soft_init = do_write && (aw_addr == ssc_pkg::OFS_CTRL) && w_strb[0]
                     && w_data[ssc_pkg::CTRL_INIT_BIT];

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg <= ssc_pkg::CFG_RESET;
      pair_map <= ssc_pkg::MAP_RESET;
      mask <= 32'h0000_0000;
    end else if (ce && do_write) begin
      if (aw_addr == ssc_pkg::OFS_CFG) begin
        cfg <= ssc_pkg::CFG_W'(apply_strb(32'(cfg), w_data, w_strb));
      end else if (aw_addr == ssc_pkg::OFS_MAP) begin
        pair_map <= 8'(apply_strb({24'h000000, pair_map}, w_data, w_strb));
      end else if (aw_addr == ssc_pkg::OFS_MASK) begin
        mask <= apply_strb(mask, w_data, w_strb) & ssc_pkg::STAT_IMPL;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Sequencer: fake measurements after init, then real cycles.
  assign fake_goal = ssc_pkg::ssc_fake_count(init_pend ? cfg.dummy_count :
                                             act_cfg.dummy_count);

  always_comb begin
    next_state = state;
    case (state)
      ssc_pkg::SSC_IDLE: begin
        if (seq_start) begin
          next_state = (fake_goal == 3'h0) ? ssc_pkg::SSC_RUN : ssc_pkg::SSC_FAKE;
        end
      end
      ssc_pkg::SSC_FAKE: begin
        if (cycle_done && (fake_cnt + 3'h1 == fake_goal)) begin
          next_state = ssc_pkg::SSC_RUN;
        end
      end
      ssc_pkg::SSC_RUN: begin
        next_state = ssc_pkg::SSC_RUN;
      end
      default: begin
        next_state = ssc_pkg::SSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ssc_pkg::SSC_IDLE;
      init_pend <= 1'b1;
      fake_cnt <= 3'h0;
      act_cfg <= ssc_pkg::CFG_RESET;
      act_map <= ssc_pkg::MAP_RESET;
    end else if (ce) begin
      if (soft_init) begin
        state <= ssc_pkg::SSC_IDLE;
        init_pend <= 1'b1;
        fake_cnt <= 3'h0;
      end else begin
        if (state == ssc_pkg::SSC_IDLE && seq_start && init_pend) begin
          act_cfg <= cfg;
          act_map <= pair_map;
          init_pend <= 1'b0;
        end
        if (state == ssc_pkg::SSC_FAKE && cycle_done) begin
          fake_cnt <= fake_cnt + 3'h1;
        end
        state <= next_state;
      end
    end
  end

  // The goal follows the written setup while an init is pending, as the copy loads at the start.
  assign ev_fake_done = (state == ssc_pkg::SSC_FAKE) && (next_state == ssc_pkg::SSC_RUN);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Calibration pacing.
  assign cal_period = (act_cfg.calib_interval == ssc_pkg::CAL_TOP_CODE) ?
                      ssc_pkg::CAL_TOP_PERIOD : act_cfg.calib_interval + 4'h1;

  always_ff @(posedge clk) begin
    if (srst) begin
      cal_cnt <= 4'h0;
      calib_req <= 1'b0;
    end else if (ce) begin
      calib_req <= 1'b0;
      if (soft_init) begin
        cal_cnt <= 4'h0;
      end else if (cycle_done && state != ssc_pkg::SSC_IDLE) begin
        if (cal_cnt + 4'h1 >= cal_period) begin
          cal_cnt <= 4'h0;
          calib_req <= 1'b1;
        end else begin
          cal_cnt <= cal_cnt + 4'h1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Driver pair routing. Several positions may land on one pair; the drives simply OR.
  for (genvar p = 0; p < 4; p++) begin : g_pair
    logic hit;
    always_comb begin
      hit = 1'b0;
      for (int i = 0; i < 4; i++) begin
        hit = hit | (drive_pos[i] & sel_hit(act_map, i, p));
      end
    end
    assign pair_hit[p] = hit;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      port_pair_drive <= 4'h0;
    end else if (ce) begin
      port_pair_drive <= pair_hit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Oscillator switch-off and fake indication.
  always_ff @(posedge clk) begin
    if (srst) begin
      osc_off <= 1'b0;
      fake_active <= 1'b0;
    end else if (ce) begin
      osc_off <= act_cfg.single_conv && act_cfg.osc_off_en && !conv_busy && !div_busy;
      fake_active <= (next_state == ssc_pkg::SSC_FAKE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Result formula. Both modes share the numerator r1 - r2; only the denominator differs.
  always_comb begin
    sdiff = {1'b0, gauge_r1} - {1'b0, gauge_r2};
    mag = sdiff[ssc_pkg::RES_W] ? ssc_pkg::RES_W'(-sdiff) : sdiff[ssc_pkg::RES_W-1:0];
    num_mag = ssc_pkg::NUM_W'(mag) * ssc_pkg::NUM_W'(ssc_pkg::PPM_SCALE);
    if (act_cfg.quarter_bridge) begin
      den = {gauge_r2, 1'b0};
    end else begin
      den = {1'b0, gauge_r1} + {1'b0, gauge_r2};
    end
  end

  // Results during fake cycles are dropped, so no post-processing happens for them.
  assign div_start = gauge_valid && (state == ssc_pkg::SSC_RUN) && !div_busy;
  // A division still running across an init must not surface during fake cycles.
  assign div_keep = div_done && (state == ssc_pkg::SSC_RUN);

  ssc_divider u_div (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .start(div_start),
    .num_mag(num_mag),
    .den(den),
    .neg(sdiff[ssc_pkg::RES_W]),
    .busy(div_busy),
    .done(div_done),
    .quot(div_quot)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      result_ppm <= 32'h0000_0000;
      result_valid <= 1'b0;
    end else if (ce) begin
      result_valid <= div_keep;
      if (div_keep) begin
        result_ppm <= div_quot;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Sticky status with write-one-to-clear; a new event beats a clear in the same cycle.
  assign ev_conflict = first_arith_unit_ram && second_arith_unit_ram;

  always_ff @(posedge clk) begin
    if (srst) begin
      status <= 32'h0000_0000;
    end else if (ce) begin
      logic [31:0] clr;
      logic [31:0] set;
      clr = (do_write && aw_addr == ssc_pkg::OFS_STAT) ?
            apply_strb(32'h0000_0000, w_data, w_strb) : 32'h0000_0000;
      set = 32'h0000_0000;
      set[ssc_pkg::ST_CONFLICT] = ev_conflict;
      set[ssc_pkg::ST_RESULT] = div_keep;
      set[ssc_pkg::ST_FAKE_DONE] = ev_fake_done;
      status <= ((status & ~clr) | set) & ssc_pkg::STAT_IMPL;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(status & mask);
    end
  end
endmodule // ssc_top
`default_nettype wire

// ### bench/ssc_top_asserts.sv
// Port-level checker for the strain sequence configuration block.
`default_nettype none
module ssc_top_asserts (
  // Clocking.
  input wire logic clk,
  input wire logic srst,
  // Bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Core side.
  input wire logic [3:0] drive_pos,
  input wire logic [3:0] port_pair_drive,
  input wire logic conv_busy,
  input wire logic osc_off,
  input wire logic cycle_done,
  input wire logic calib_req,
  input wire logic result_valid,
  input wire logic fake_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read data late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_drive_zero;
    drive_pos == 4'h0 |=> port_pair_drive == 4'h0;
  endproperty
  a_drive_zero: assert property (p_drive_zero) else $error("idle pair driven");
  property p_drive_any;
    drive_pos != 4'h0 |=> port_pair_drive != 4'h0;
  endproperty
  a_drive_any: assert property (p_drive_any) else $error("drive lost");
  property p_osc;
    conv_busy |=> !osc_off;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator off in conversion");
  property p_calib;
    calib_req |-> $past(cycle_done) && !$past(calib_req);
  endproperty
  a_calib: assert property (p_calib) else $error("calibration without cycle");
  property p_fake_nores;
    fake_active |-> !result_valid;
  endproperty
  a_fake_nores: assert property (p_fake_nores) else $error("result in fake cycle");
endmodule // ssc_top_asserts
bind ssc_top ssc_top_asserts u_chk (.clk, .srst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .drive_pos, .port_pair_drive, .conv_busy, .osc_off,
  .cycle_done, .calib_req, .result_valid, .fake_active);
`default_nettype wire

// ### bench/ssc_core_model.sv
// Behavioural measurement core that feeds the sequencer's status and gauge inputs.
`default_nettype none
module ssc_core_model (
  // Clock.
  input wire logic clk,
  // Core status.
  output logic seq_start,
  output logic cycle_done,
  output logic ram_a,
  output logic ram_b,
  output logic conv_busy,
  // Gauge data.
  output logic gauge_valid,
  output logic [ssc_pkg::RES_W-1:0] r1,
  output logic [ssc_pkg::RES_W-1:0] r2
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {seq_start, cycle_done, ram_a, ram_b, conv_busy, gauge_valid} = 6'h00;
    r1 = 16'h0000;
    r2 = 16'h0000;
  end
  task automatic start();
    seq_start <= 1'b1;
    @(posedge clk);
    seq_start <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cycle();
    cycle_done <= 1'b1;
    @(posedge clk);
    cycle_done <= 1'b0;
    @(posedge clk);
  endtask
  // Both units grab the RAM in the same clock, for one cycle.
  task automatic clash();
    ram_a <= 1'b1;
    ram_b <= 1'b1;
    @(posedge clk);
    ram_a <= 1'b0;
    ram_b <= 1'b0;
    @(posedge clk);
  endtask
  // The active gauge sits on pair A and its reference on pair B, so r1 is the gauge.
  // Data are inverted once stale, so a late sampler reads garbage.
  task automatic gauge(input logic [15:0] a, input logic [15:0] b);
    r1 <= a;
    r2 <= b;
    gauge_valid <= 1'b1;
    @(posedge clk);
    gauge_valid <= 1'b0;
    r1 <= ~a;
    r2 <= ~b;
    @(posedge clk);
  endtask
  task automatic busy(input logic v);
    conv_busy <= v;
    @(posedge clk);
  endtask
endmodule // ssc_core_model
`default_nettype wire

// ### bench/ssc_top_tb.sv
// Self-checking testbench for the strain sequence configuration block.
`default_nettype none
module ssc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, res, dat;
  logic [3:0] dp = 4'h0, ppd;
  logic [1:0] br, rr, rsp;
  logic awr, wr_rdy, bv, arr, rv, irq, fake, cal, osc, resv;
  logic sst, cdn, ra, rb, cb, gv;
  logic [15:0] g1, g2;
  int num_errors = 0, tests_run = 0, nres = 0, ncal = 0;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (resv === 1'b1) nres++;
    if (cal === 1'b1) ncal++;
  end
  ssc_core_model core (.clk(clk), .seq_start(sst), .cycle_done(cdn), .ram_a(ra), .ram_b(rb),
    .conv_busy(cb), .gauge_valid(gv), .r1(g1), .r2(g2));
  ssc_top dut (.clk(clk), .srst(srst), .ce(1'b1), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .irq(irq), .seq_start(sst),
    .cycle_done(cdn), .first_arith_unit_ram(ra), .second_arith_unit_ram(rb), .conv_busy(cb),
    .gauge_valid(gv), .gauge_r1(g1), .gauge_r2(g2), .drive_pos(dp), .port_pair_drive(ppd),
    .fake_active(fake), .calib_req(cal), .osc_off(osc), .result_ppm(res), .result_valid(resv));
  task automatic stop_test();
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tmo();
    num_errors++;
    stop_test();
  endtask
  // Address and data are offered together and each is released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    awa <= a;
    awv <= 1'b1;
    wd <= d;
    wv <= 1'b1;
    bry <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (bv === 1'b1) begin
        r = br;
        bry <= 1'b0;
        break;
      end
      if (awr === 1'b1) awv <= 1'b0;
      if (wr_rdy === 1'b1) wv <= 1'b0;
    end
    @(posedge clk);
    if (i == 50) tmo();
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (rv === 1'b1) begin
        d = rd;
        r = rr;
        rry <= 1'b0;
        break;
      end
      if (arr === 1'b1) arv <= 1'b0;
    end
    @(posedge clk);
    if (i == 50) tmo();
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    rdr(a, dat, rsp);
    chk(n, e, dat);
  endtask
  // Settings only reach the core through an init followed by a new sequence.
  task automatic setup(input logic [31:0] c, input logic [31:0] m);
    wr(ssc_pkg::OFS_CFG, c, rsp);
    wr(ssc_pkg::OFS_MAP, m, rsp);
    wr(ssc_pkg::OFS_CTRL, 32'h0000_0001, rsp);
    core.start();
  endtask
  task automatic drv(input logic [3:0] v, input logic [3:0] e);
    dp <= v;
    repeat (3) @(posedge clk);
    chk("port pairs", {28'h0, e}, {28'h0, ppd});
  endtask
  task automatic t_regs();
    rchk("cfg", ssc_pkg::OFS_CFG, 32'h0);
    rchk("map", ssc_pkg::OFS_MAP, 32'h0000_00E4);
    rchk("mask", ssc_pkg::OFS_MASK, 32'h0);
    rchk("status", ssc_pkg::OFS_STAT, 32'h0);
    rchk("ctrl", ssc_pkg::OFS_CTRL, 32'h0000_0001);
    rchk("result", ssc_pkg::OFS_RESULT, 32'h0);
    wr(8'h18, 32'hFFFF_FFFF, rsp);
    chk("bresp", {30'h0, ssc_pkg::RESP_SLVERR}, {30'h0, rsp});
    rchk("unmapped", 8'h18, 32'h0);
    chk("rresp", {30'h0, ssc_pkg::RESP_SLVERR}, {30'h0, rsp});
  endtask
  task automatic t_map();
    core.start();
    for (int i = 0; i < 4; i++) drv(4'h1 << i, 4'h1 << i);
    wr(ssc_pkg::OFS_MAP, 32'h0000_001B, rsp);
    drv(4'h1, 4'h1);
    setup(32'h0, 32'h0000_001B);
    for (int i = 0; i < 4; i++) drv(4'h1 << i, 4'h8 >> i);
    setup(32'h0, 32'h0000_00AA);
    drv(4'hF, 4'h4);
    drv(4'h0, 4'h0);
  endtask
  task automatic t_fake();
    int fk[4] = '{0, 1, 2, 4};
    int n;
    int n0;
    for (int c = 0; c < 4; c++) begin
      setup(c, 32'h0000_00E4);
      n0 = nres;
      if (c == 3) core.gauge(16'h0064, 16'h0032);
      n = 0;
      repeat (2) @(posedge clk);
      while (fake === 1'b1 && n < 8) begin
        core.cycle();
        repeat (2) @(posedge clk);
        n++;
      end
      chk("fake count", fk[c], n);
      repeat (50) @(posedge clk);
      chk("fake results", n0, nres);
    end
  endtask
  task automatic t_cal(input logic [3:0] code, input int cyc, input int exp);
    setup({26'h0, code, 2'h0}, 32'h0000_00E4);
    ncal = 0;
    repeat (cyc) core.cycle();
    repeat (2) @(posedge clk);
    chk("calibrations", exp, ncal);
  endtask
  task automatic res_chk(input logic [15:0] a, input logic [15:0] b, input logic [31:0] e);
    int i;
    core.gauge(a, b);
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (resv === 1'b1) break;
    end
    if (i == 100) tmo();
    chk("ppm", e, res);
  endtask
  task automatic t_res();
    wr(ssc_pkg::OFS_STAT, 32'hFFFF_FFFF, rsp);
    setup(32'h0, 32'h0000_00E4);
    res_chk(16'd300, 16'd100, 32'h0007_A120);
    res_chk(16'd100, 16'd300, 32'hFFF8_5EE0);
    rchk("status", ssc_pkg::OFS_STAT, 32'h0000_0001);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(ssc_pkg::OFS_MASK, 32'h0000_0001, rsp);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(ssc_pkg::OFS_STAT, 32'h0000_0001, rsp);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    setup(32'h0000_0040, 32'h0000_00E4);
    res_chk(16'd300, 16'd200, 32'h0003_D090);
    wr(ssc_pkg::OFS_STAT, 32'h0000_0001, rsp);
    core.clash();
    rchk("status", ssc_pkg::OFS_STAT, 32'h0008_0000);
  endtask
  task automatic t_osc();
    setup(32'h0000_0180, 32'h0000_00E4);
    core.busy(1'b0);
    repeat (3) @(posedge clk);
    chk("osc off", 32'h1, {31'h0, osc});
    core.busy(1'b1);
    repeat (3) @(posedge clk);
    chk("osc on", 32'h0, {31'h0, osc});
  endtask
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_map();
    t_fake();
    t_cal(4'h0, 3, 3);
    t_cal(4'h2, 6, 2);
    t_cal(4'hF, 15, 1);
    t_res();
    t_osc();
    stop_test();
  end
endmodule // ssc_top_tb
`default_nettype wire
